// >>> rtl/afe_cfg_pkg.sv
// constants for the first time slot front end configuration registers
package afe_cfg_pkg;

    // ========================================================================
    // register addresses on the serial control port
    // ========================================================================
    localparam logic [7:0]  ADDR_WINDOW    = 8'h39;   // integration window register
    localparam logic [7:0]  ADDR_MODE_GAIN = 8'h42;   // front end mode and gain register
    localparam logic [7:0]  ADDR_CH_GAIN   = 8'h55;   // per channel gain register

    // ========================================================================
    // reset values
    // ========================================================================
    localparam logic [15:0] RST_WINDOW     = 16'h22fc; // width 0x4, offset 0x2fc
    localparam logic [15:0] RST_MODE_GAIN  = 16'h1c38; // mode 0x07, vref 0x3, rsvd 0x2
    localparam logic [15:0] RST_CH_GAIN    = 16'h0000; // all channel gains 0
    localparam logic [15:0] CH_GAIN_MASK   = 16'h003f; // bits held for this slot
    localparam logic [15:0] READ_MISS_DATA = 16'h0000; // answer to an unmapped read

    // ========================================================================
    // field positions
    // ========================================================================
    localparam int WIDTH_MSB   = 15;  // window width, 1 us steps
    localparam int WIDTH_LSB   = 11;
    localparam int OFFSET_MSB  = 10;  // window offset, 31.25 ns steps
    localparam int OFFSET_LSB  = 0;
    localparam int MODE_MSB    = 15;  // fixed mode field
    localparam int MODE_LSB    = 10;
    localparam int INT_MSB     = 9;   // integrator gain
    localparam int INT_LSB     = 8;
    localparam int INT_BUF_BIT = 7;   // integrator as buffer
    localparam int PER_CH_BIT  = 6;   // per channel gain enable
    localparam int VREF_MSB    = 5;   // amplifier reference
    localparam int VREF_LSB    = 4;
    localparam int TIA_MSB     = 1;   // shared / channel 1 gain
    localparam int TIA_LSB     = 0;
    localparam int CH_FIELD_W  = 2;   // width of one channel gain code
    localparam int NUM_CH      = 4;   // channels in the slot

    // ========================================================================
    // step sizes for the timing core
    // ========================================================================
    localparam int WIDTH_STEP_NS  = 1000;  // 1 us per width code
    localparam int OFFSET_STEP_PS = 31250; // 31.25 ns per offset code

    // ========================================================================
    // encodings
    // ========================================================================
    typedef enum logic [1:0]
    {
        TIA_200K = 2'h0,
        TIA_100K = 2'h1,
        TIA_50K  = 2'h2,
        TIA_25K  = 2'h3
    } tia_gain_t;

    typedef enum logic [1:0]
    {
        INT_400K = 2'h0,
        INT_200K = 2'h1,
        INT_100K = 2'h2,
        INT_RSVD = 2'h3
    } int_gain_t;

    typedef enum logic [1:0]
    {
        VREF_1V14 = 2'h0,
        VREF_1V01 = 2'h1,
        VREF_0V90 = 2'h2,
        VREF_1V27 = 2'h3
    } vref_t;

    // one-hot selects toward the analog side
    localparam logic [2:0] RES_SEL_NONE = 3'h0;  // integrator used as buffer
    localparam logic [2:0] RES_SEL_100K = 3'h1;
    localparam logic [2:0] RES_SEL_200K = 3'h2;
    localparam logic [2:0] RES_SEL_400K = 3'h4;
    localparam logic [1:0] BUF_SEL_NONE = 2'h0;  // normal integrator
    localparam logic [1:0] BUF_SEL_UNIT = 2'h1;  // buffer gain 1.0
    localparam logic [1:0] BUF_SEL_0P7  = 2'h2;  // buffer gain 0.7
    localparam logic [3:0] FB_SEL_200K  = 4'h1;
    localparam logic [3:0] FB_SEL_100K  = 4'h2;
    localparam logic [3:0] FB_SEL_50K   = 4'h4;
    localparam logic [3:0] FB_SEL_25K   = 4'h8;

endpackage

// >>> rtl/gain_channel_select.sv
// one channel of transimpedance gain selection and feedback decode
`timescale 1ns/1ps
`default_nettype none

module gain_channel_select
(
    input  wire logic       clock,          // device clock
    input  wire logic       arst_n,         // async reset, active low
    input  wire logic       enable,         // clock enable
    input  wire logic       per_ch_en,      // use the channel's own code
    input  wire logic [1:0] shared_gain,    // code common to all channels
    input  wire logic [1:0] own_gain,       // this channel's own code
    output logic      [1:0] gain_q,         // applied gain code
    output logic      [3:0] feedback_sel_q  // one-hot feedback resistor
);

    // ========================================================================
    // selection and decode
    // ========================================================================
    logic [1:0] gain_d;  // code picked for this channel
    logic [3:0] fb_d;    // decoded resistor select

    // pick own or shared code, then decode it
    always_comb
    begin
        gain_d = per_ch_en ? own_gain : shared_gain;
        case (gain_d)
            afe_cfg_pkg::TIA_200K: fb_d = afe_cfg_pkg::FB_SEL_200K;
            afe_cfg_pkg::TIA_100K: fb_d = afe_cfg_pkg::FB_SEL_100K;
            afe_cfg_pkg::TIA_50K:  fb_d = afe_cfg_pkg::FB_SEL_50K;
            default:               fb_d = afe_cfg_pkg::FB_SEL_25K;
        endcase
    end

    // register the result toward the analog side
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gain_q         <= afe_cfg_pkg::TIA_200K;
            feedback_sel_q <= afe_cfg_pkg::FB_SEL_200K;
        end
        else if (enable)
        begin
            gain_q         <= gain_d;
            feedback_sel_q <= fb_d;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/slot_a_afe_config_regs.sv
// first time slot front end configuration register bank
`timescale 1ns/1ps
`default_nettype none

module slot_a_afe_config_regs
(
    input  wire logic        clock,                          // 10 MHz device clock
    input  wire logic        arst_n,                         // async reset, active low
    input  wire logic        enable,                         // clock enable, freezes all
    input  wire logic [7:0]  reg_addr,                       // register address
    input  wire logic [15:0] reg_wdata,                      // write data
    input  wire logic        reg_wr_en,                      // write strobe
    input  wire logic        reg_rd_en,                      // read strobe
    output logic      [15:0] reg_rdata,                      // read data
    output logic             reg_rd_valid,                   // read data valid pulse
    output logic             reg_addr_miss,                  // unmapped access pulse
    output logic      [4:0]  first_slot_window_width,        // window length, 1 us steps
    output logic      [10:0] first_slot_window_offset,       // window start, 31.25 ns steps
    output logic      [5:0]  first_slot_frontend_mode,       // fixed mode field
    output logic             first_slot_integrator_buffer,   // integrator acts as buffer
    output logic      [2:0]  first_slot_integrator_res_sel,  // one-hot 100k/200k/400k
    output logic      [1:0]  first_slot_buffer_gain_sel,     // one-hot unity/0.7
    output logic      [1:0]  first_slot_amp_reference,       // reference code
    output logic             first_slot_per_channel_gain_en, // per channel gains on
    output logic      [7:0]  first_slot_ch_gain,             // applied codes, ch1 low
    output logic      [15:0] first_slot_ch_feedback_sel      // one-hot per channel
);

    // ========================================================================
    // register storage
    // ========================================================================
    logic [15:0] window_q;     // integration window register
    logic [15:0] mode_gain_q;  // mode and gain register
    logic [15:0] ch_gain_q;    // per channel gain register, low six bits
    logic        hit_window;   // address decodes
    logic        hit_mode;
    logic        hit_ch;
    logic        wr_go;        // qualified write
    logic        rd_go;        // qualified read

    assign hit_window = (reg_addr == afe_cfg_pkg::ADDR_WINDOW);
    assign hit_mode   = (reg_addr == afe_cfg_pkg::ADDR_MODE_GAIN);
    assign hit_ch     = (reg_addr == afe_cfg_pkg::ADDR_CH_GAIN);
    assign wr_go      = enable && reg_wr_en;
    assign rd_go      = enable && reg_rd_en;

    // window register, width and offset fields
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            window_q <= afe_cfg_pkg::RST_WINDOW;
        else if (wr_go && hit_window)
            window_q <= reg_wdata;
    end

    // mode and gain register, stores every bit as written
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mode_gain_q <= afe_cfg_pkg::RST_MODE_GAIN;
        else if (wr_go && hit_mode)
            mode_gain_q <= reg_wdata;
    end

    // per channel gain register, other slot bits read zero
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ch_gain_q <= afe_cfg_pkg::RST_CH_GAIN;
        else if (wr_go && hit_ch)
            ch_gain_q <= reg_wdata & afe_cfg_pkg::CH_GAIN_MASK;
    end

    // ========================================================================
    // read port
    // ========================================================================
    logic [15:0] rdata_d;  // read mux
    logic        miss_d;   // address not mapped

    // select register by address
    always_comb
    begin
        rdata_d = afe_cfg_pkg::READ_MISS_DATA;
        miss_d  = 1'b0;
        case (reg_addr)
            afe_cfg_pkg::ADDR_WINDOW:    rdata_d = window_q;
            afe_cfg_pkg::ADDR_MODE_GAIN: rdata_d = mode_gain_q;
            afe_cfg_pkg::ADDR_CH_GAIN:   rdata_d = ch_gain_q;
            default:                     miss_d  = 1'b1;
        endcase
    end

    // register read answer one cycle after the strobe
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata     <= afe_cfg_pkg::READ_MISS_DATA;
            reg_rd_valid  <= 1'b0;
            reg_addr_miss <= 1'b0;
        end
        else if (enable)
        begin
            if (reg_rd_en)
                reg_rdata <= rdata_d;
            reg_rd_valid  <= reg_rd_en;
            reg_addr_miss <= (reg_rd_en || reg_wr_en) && miss_d;
        end
    end

    // ========================================================================
    // configuration outputs
    // ========================================================================
    logic [1:0] int_code;   // integrator gain field
    logic       int_buf;    // integrator as buffer
    logic [2:0] res_sel_d;  // integrator resistor select
    logic [1:0] buf_sel_d;  // buffer gain select

    assign int_code = mode_gain_q[afe_cfg_pkg::INT_MSB:afe_cfg_pkg::INT_LSB];
    assign int_buf  = mode_gain_q[afe_cfg_pkg::INT_BUF_BIT];

    // decode integrator gain for the active configuration
    always_comb
    begin
        res_sel_d = afe_cfg_pkg::RES_SEL_NONE;
        buf_sel_d = afe_cfg_pkg::BUF_SEL_NONE;
        if (int_buf)
        begin
            // reserved code treated as the 0.7 setting
            if (int_code == afe_cfg_pkg::INT_400K || int_code == afe_cfg_pkg::INT_200K)
                buf_sel_d = afe_cfg_pkg::BUF_SEL_UNIT;
            else
                buf_sel_d = afe_cfg_pkg::BUF_SEL_0P7;
        end
        else
        begin
            case (int_code)
                afe_cfg_pkg::INT_400K: res_sel_d = afe_cfg_pkg::RES_SEL_400K;
                afe_cfg_pkg::INT_200K: res_sel_d = afe_cfg_pkg::RES_SEL_200K;
                default:               res_sel_d = afe_cfg_pkg::RES_SEL_100K;
            endcase
        end
    end

    // window timing toward the timing core
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            first_slot_window_width  <= afe_cfg_pkg::RST_WINDOW[afe_cfg_pkg::WIDTH_MSB:
                                                                afe_cfg_pkg::WIDTH_LSB];
            first_slot_window_offset <= afe_cfg_pkg::RST_WINDOW[afe_cfg_pkg::OFFSET_MSB:
                                                                afe_cfg_pkg::OFFSET_LSB];
        end
        else if (enable)
        begin
            first_slot_window_width  <= window_q[afe_cfg_pkg::WIDTH_MSB:
                                                 afe_cfg_pkg::WIDTH_LSB];
            first_slot_window_offset <= window_q[afe_cfg_pkg::OFFSET_MSB:
                                                 afe_cfg_pkg::OFFSET_LSB];
        end
    end

    // amplifier and integrator settings toward the analog side
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            first_slot_frontend_mode       <= afe_cfg_pkg::RST_MODE_GAIN[afe_cfg_pkg::MODE_MSB:
                                                                      afe_cfg_pkg::MODE_LSB];
            first_slot_integrator_buffer   <= 1'b0;
            first_slot_integrator_res_sel  <= afe_cfg_pkg::RES_SEL_400K;
            first_slot_buffer_gain_sel     <= afe_cfg_pkg::BUF_SEL_NONE;
            first_slot_amp_reference       <= afe_cfg_pkg::VREF_1V27;
            first_slot_per_channel_gain_en <= 1'b0;
        end
        else if (enable)
        begin
            first_slot_frontend_mode       <= mode_gain_q[afe_cfg_pkg::MODE_MSB:
                                                          afe_cfg_pkg::MODE_LSB];
            first_slot_integrator_buffer   <= int_buf;
            first_slot_integrator_res_sel  <= res_sel_d;
            first_slot_buffer_gain_sel     <= buf_sel_d;
            first_slot_amp_reference       <= mode_gain_q[afe_cfg_pkg::VREF_MSB:
                                                          afe_cfg_pkg::VREF_LSB];
            first_slot_per_channel_gain_en <= mode_gain_q[afe_cfg_pkg::PER_CH_BIT];
        end
    end

    // ========================================================================
    // per channel gain selection
    // ========================================================================
    genvar ch;
    generate
        for (ch = 0; ch < afe_cfg_pkg::NUM_CH; ch++)
        begin : g_ch
            logic [1:0] own_code;  // channel's own code
            if (ch == 0)
            begin : g_first
                // channel 1 always reads the local field
                assign own_code = mode_gain_q[afe_cfg_pkg::TIA_MSB:afe_cfg_pkg::TIA_LSB];
            end
            else
            begin : g_rest
                // channels 2..4 packed upward from bit 0
                assign own_code = ch_gain_q[(ch - 1) * afe_cfg_pkg::CH_FIELD_W +: 2];
            end
            gain_channel_select u_sel
            (
                .clock          (clock),
                .arst_n         (arst_n),
                .enable         (enable),
                .per_ch_en      (mode_gain_q[afe_cfg_pkg::PER_CH_BIT]),
                .shared_gain    (mode_gain_q[afe_cfg_pkg::TIA_MSB:afe_cfg_pkg::TIA_LSB]),
                .own_gain       (own_code),
                .gain_q         (first_slot_ch_gain[ch * 2 +: 2]),
                .feedback_sel_q (first_slot_ch_feedback_sel[ch * 4 +: 4])
            );
        end
    endgenerate

    // ========================================================================
    // assertions
    // ========================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_WIDTH: assert property (
        (wr_go && hit_window) ##1 enable |=>
            first_slot_window_width == $past(reg_wdata[15:11], 2))
        else $error("window width not taken from write");

    AST_OFFSET: assert property (
        (wr_go && hit_window) ##1 enable |=>
            first_slot_window_offset == $past(reg_wdata[10:0], 2))
        else $error("window offset not taken from write");

    AST_INT_RES: assert property (
        $past(enable) && !$past(int_buf) && $past(int_code) == afe_cfg_pkg::INT_400K |->
            first_slot_integrator_res_sel == afe_cfg_pkg::RES_SEL_400K)
        else $error("integrator resistor select wrong");

    AST_BUF_GAIN: assert property (
        $past(enable) && $past(int_buf) && $past(int_code) == afe_cfg_pkg::INT_100K |->
            first_slot_buffer_gain_sel == afe_cfg_pkg::BUF_SEL_0P7 &&
            first_slot_integrator_res_sel == afe_cfg_pkg::RES_SEL_NONE)
        else $error("buffer gain select wrong");

    AST_BUF_MODE: assert property (
        (wr_go && hit_mode) ##1 enable |=>
            first_slot_integrator_buffer == $past(reg_wdata[7], 2))
        else $error("buffer mode bit not applied");

    AST_CH_INDIV: assert property (
        $past(enable) && $past(mode_gain_q[6]) |->
            first_slot_ch_gain[7:6] == $past(ch_gain_q[5:4]) &&
            first_slot_ch_gain[1:0] == $past(mode_gain_q[1:0]))
        else $error("channel 4 or 1 gain not individual");

    AST_CH_SHARED: assert property (
        $past(enable) && !$past(mode_gain_q[6]) |->
            first_slot_ch_gain == {4{$past(mode_gain_q[1:0])}})
        else $error("shared gain not applied to all channels");

    AST_FB_SEL: assert property (
        (first_slot_ch_gain[7:6] == afe_cfg_pkg::TIA_25K) ==
        (first_slot_ch_feedback_sel[15:12] == afe_cfg_pkg::FB_SEL_25K))
        else $error("channel 4 feedback decode wrong");

    AST_VREF: assert property (
        (wr_go && hit_mode) ##1 enable |=>
            first_slot_amp_reference == $past(reg_wdata[5:4], 2))
        else $error("reference code not applied");

    AST_CH2: assert property (
        $past(enable) && $past(mode_gain_q[6]) |->
            first_slot_ch_gain[3:2] == $past(ch_gain_q[1:0]))
        else $error("channel 2 gain from wrong bits");

    AST_MISS: assert property (
        rd_go && !(hit_window || hit_mode || hit_ch) |=>
            reg_addr_miss && reg_rd_valid && reg_rdata == afe_cfg_pkg::READ_MISS_DATA)
        else $error("unmapped read not answered as miss");

    AST_FREEZE: assert property (
        !enable |=> $stable(first_slot_ch_gain) && $stable(first_slot_window_width))
        else $error("state moved while enable low");

    COV_CH_WRITE: cover property (wr_go && hit_ch);
    COV_INDIV_25K: cover property (first_slot_per_channel_gain_en &&
                                   first_slot_ch_gain[7:6] == afe_cfg_pkg::TIA_25K);
    COV_BUF_0P7: cover property (first_slot_buffer_gain_sel == afe_cfg_pkg::BUF_SEL_0P7);
    COV_MISS: cover property (reg_addr_miss);

endmodule

`default_nettype wire

// >>> sim/host_port_model.sv
// host side model that drives the register access port
`timescale 1ns/1ps
`default_nettype none

module host_port_model
(
    input  wire logic        clock,        // device clock
    input  wire logic        reg_rd_valid, // read answer valid
    input  wire logic [15:0] reg_rdata,    // read answer
    output logic      [7:0]  reg_addr,     // requested address
    output logic      [15:0] reg_wdata,    // write data
    output logic             reg_wr_en,    // write strobe
    output logic             reg_rd_en     // read strobe
);
    // ========================================================================
    // idle port at time zero
    // ========================================================================
    initial
    begin
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end

    // one write, strobe high for a single cycle, data scrambled once taken
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    begin
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr_en <= 1'b1;
        @(posedge clock);
        reg_wr_en <= 1'b0;
        reg_wdata <= ~d;
    end
    endtask

    // one read, waits a bounded number of cycles for the answer
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
        int n;
    begin
        @(posedge clock);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge clock);
        reg_rd_en <= 1'b0;
        ok = 1'b0;
        for (n = 0; n < 4 && !ok; n++)
        begin
            #1;
            if (reg_rd_valid === 1'b1)
                ok = 1'b1;
            else
                @(posedge clock);
        end
        d = reg_rdata;
    end
    endtask
endmodule

`default_nettype wire

// >>> sim/slot_a_afe_config_regs_test.sv
// self-checking bench for the first slot configuration registers
`timescale 1ns/1ps
`default_nettype none

module slot_a_afe_config_regs_test;
    logic        clock, arst_n, enable, wr_en, rd_en, rd_valid, miss, int_buf, per_en, ok;
    logic [7:0]  addr, ch_gain;
    logic [15:0] wdata, rdata, fb_sel, rd;
    logic [4:0]  width;
    logic [10:0] offset;
    logic [5:0]  mode;
    logic [2:0]  res_sel;
    logic [1:0]  buf_sel, amp_ref;
    int          mismatches, num_checks;

    // ========================================================================
    // clock, reset and instances
    // ========================================================================
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    slot_a_afe_config_regs i_slot_a_afe_config_regs
    (
        .clock(clock), .arst_n(arst_n), .enable(enable), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_rdata(rdata),
        .reg_rd_valid(rd_valid), .reg_addr_miss(miss), .first_slot_window_width(width),
        .first_slot_window_offset(offset), .first_slot_frontend_mode(mode),
        .first_slot_integrator_buffer(int_buf), .first_slot_integrator_res_sel(res_sel),
        .first_slot_buffer_gain_sel(buf_sel), .first_slot_amp_reference(amp_ref),
        .first_slot_per_channel_gain_en(per_en), .first_slot_ch_gain(ch_gain),
        .first_slot_ch_feedback_sel(fb_sel)
    );

    host_port_model i_host_port_model
    (
        .clock(clock), .reg_rd_valid(rd_valid), .reg_rdata(rdata), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr_en(wr_en), .reg_rd_en(rd_en)
    );

    // ========================================================================
    // compare, read and write helpers
    // ========================================================================
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask

    task automatic close_out;
    begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    // read and compare, a missing answer counts as a mismatch
    task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
    begin
        i_host_port_model.read_reg(a, rd, ok);
        check("rd_valid", {15'h0, ok}, 16'h0001);
        check("rdata", rd, exp);
        // answer never came: the wait ran out, report and stop
        if (ok !== 1'b1)
            close_out();
    end
    endtask

    // mode register write with fixed fields, then wait until outputs follow
    task automatic wr42(input logic [1:0] ig, input logic bf, input logic pe,
                        input logic [1:0] vr, input logic [1:0] tg);
    begin
        i_host_port_model.write_reg(afe_cfg_pkg::ADDR_MODE_GAIN,
                                    {6'h07, ig, bf, pe, vr, 2'h1, tg});
        @(posedge clock);
        #1;
    end
    endtask

    // ========================================================================
    // main sequence
    // ========================================================================
    initial
    begin
        arst_n = 1'b0;
        enable = 1'b1;
        mismatches = 0;
        num_checks = 0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        read_check(afe_cfg_pkg::ADDR_WINDOW, 16'h22fc);
        read_check(afe_cfg_pkg::ADDR_MODE_GAIN, 16'h1c38);
        check("width", {11'h0, width}, 16'h0004);
        check("offset", {5'h0, offset}, 16'h02fc);
        check("amp_ref", {14'h0, amp_ref}, 16'h0003);
        // integrator resistance and buffer gain, both modes
        for (int b = 0; b < 2; b++)
        begin
            for (int g = 0; g < 3; g++)
            begin
                wr42(g[1:0], b[0], 1'b0, 2'h3, 2'h0);
                check("int_buf", {15'h0, int_buf}, b[15:0]);
                check("res_sel", {13'h0, res_sel}, b ? 16'h0 : 16'h4 >> g);
                check("buf_sel", {14'h0, buf_sel}, b ? (g == 2 ? 16'h2 : 16'h1) : 16'h0);
            end
        end
        // shared gain over every code, reference over every code
        for (int t = 0; t < 4; t++)
        begin
            wr42(2'h0, 1'b0, 1'b0, t[1:0], t[1:0]);
            check("ch_gain", {8'h0, ch_gain}, {8'h0, {4{t[1:0]}}});
            check("fb_sel", fb_sel, {4{4'h1 << t}});
            check("amp_ref", {14'h0, amp_ref}, t[15:0]);
            check("mode", {10'h0, mode}, 16'h0007);
        end
        // per channel gains, upper bits of the channel register dropped
        i_host_port_model.write_reg(afe_cfg_pkg::ADDR_CH_GAIN, 16'hffe4);
        wr42(2'h0, 1'b0, 1'b1, 2'h3, 2'h3);
        check("per_en", {15'h0, per_en}, 16'h0001);
        check("ch_gain", {8'h0, ch_gain}, 16'h0093);
        check("fb_sel", fb_sel, 16'h4218);
        read_check(afe_cfg_pkg::ADDR_CH_GAIN, 16'h0024);
        wr42(2'h0, 1'b0, 1'b0, 2'h3, 2'h3);
        check("ch_gain", {8'h0, ch_gain}, 16'h00ff);
        // window register extremes
        i_host_port_model.write_reg(afe_cfg_pkg::ADDR_WINDOW, 16'hf801);
        @(posedge clock);
        #1;
        check("width", {11'h0, width}, 16'h001f);
        check("offset", {5'h0, offset}, 16'h0001);
        // unmapped read answers zero and flags the miss
        read_check(8'h40, 16'h0000);
        check("miss", {15'h0, miss}, 16'h0001);
        // nothing is taken while the clock enable is low
        @(posedge clock);
        enable <= 1'b0;
        i_host_port_model.write_reg(afe_cfg_pkg::ADDR_WINDOW, 16'h0000);
        enable <= 1'b1;
        read_check(afe_cfg_pkg::ADDR_WINDOW, 16'hf801);
        close_out();
    end
endmodule

`default_nettype wire
